/* File: common/lsp_consts.vh */
`ifndef LSP_CONSTS_VH
`define LSP_CONSTS_VH
// register byte addresses
`define LSP_CFG_BASE 8'h00
`define LSP_STATUS_ADDR 8'h20
`define LSP_STRAP_ADDR 8'h24
// channel configuration register fields
`define LSP_CFG_RES_LSB 0
`define LSP_CFG_TERM_LSB 2
`define LSP_CFG_RESET 4'h0
// synchroniser fill cycles after reset before the straps may latch
`define LSP_SYNC_FILL 2'h3
// external receive resistor codes
`define LSP_RES_NONE 2'h0
`define LSP_RES_240 2'h1
`define LSP_RES_210 2'h2
`define LSP_RES_150 2'h3
// resistor values in ohms
`define LSP_OHM_240 16'h00F0
`define LSP_OHM_210 16'h00D2
`define LSP_OHM_150 16'h0096
// line impedance per termination select code, in ohms
`define LSP_TERM_0 16'h0064
`define LSP_TERM_1 16'h006E
`define LSP_TERM_2 16'h004B
`define LSP_TERM_3 16'h0078
// host processor bus flavour codes
`define LSP_BUS_FIRST 2'h0
`define LSP_BUS_SECOND 2'h1
`endif

/* File: hw/lsp_chan.v */
`timescale 1ns/1ps
`include "lsp_consts.vh"
module lsp_chan (
  input wire clk,
  input wire rst_n,
  input wire rclk_pin,
  input wire rx_pos_raw,
  input wire rx_neg_raw,
  input wire los_raw,
  input wire tclk_pin,
  input wire tx_pos_pin,
  input wire tx_neg_pin,
  input wire mute_en,
  input wire rclk_fall,
  input wire tclk_rise,
  input wire [1:0] res_code,
  input wire [1:0] term_code,
  output reg receive_positive_data_out_reg,
  output reg receive_negative_data_out_reg,
  output reg transmit_positive_data_in_reg,
  output reg transmit_negative_data_in_reg,
  output reg los_reg,
  output reg muted_reg,
  output reg [15:0] imp_reg
);
  reg [6:0] s1_reg;
  reg [6:0] s2_reg;
  reg rclk_prev_reg;
  reg tclk_prev_reg;
  reg [15:0] rext;
  reg [15:0] tgt;
  reg [15:0] imp_next;
  wire rclk_s = s2_reg[0];
  wire tclk_s = s2_reg[4];
  wire rx_edge = rclk_fall ? (rclk_prev_reg & ~rclk_s) :
                             (~rclk_prev_reg & rclk_s);
  wire tx_edge = tclk_rise ? (~tclk_prev_reg & tclk_s) :
                             (tclk_prev_reg & ~tclk_s);
  wire mute_now = mute_en & s2_reg[3];

  always @* begin
    case (res_code)
      `LSP_RES_240: rext = `LSP_OHM_240;
      `LSP_RES_210: rext = `LSP_OHM_210;
      default: rext = `LSP_OHM_150;
    endcase
    case (term_code)
      2'h0: tgt = `LSP_TERM_0;
      2'h1: tgt = `LSP_TERM_1;
      2'h2: tgt = `LSP_TERM_2;
      default: tgt = `LSP_TERM_3;
    endcase
    // internal part such that internal || external equals the target
    if (res_code == `LSP_RES_NONE) begin
      imp_next = tgt;
    end else begin
      imp_next = (rext * tgt) / (rext - tgt);
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      s1_reg <= 7'h00;
      s2_reg <= 7'h00;
      rclk_prev_reg <= 1'b0;
      tclk_prev_reg <= 1'b0;
      receive_positive_data_out_reg <= 1'b0;
      receive_negative_data_out_reg <= 1'b0;
      transmit_positive_data_in_reg <= 1'b0;
      transmit_negative_data_in_reg <= 1'b0;
      los_reg <= 1'b0;
      muted_reg <= 1'b0;
      imp_reg <= 16'h0000;
    end else begin
      s1_reg <= {tx_neg_pin, tx_pos_pin, tclk_pin, los_raw,
                 rx_neg_raw, rx_pos_raw, rclk_pin};
      s2_reg <= s1_reg;
      rclk_prev_reg <= rclk_s;
      tclk_prev_reg <= tclk_s;
      los_reg <= s2_reg[3];
      muted_reg <= mute_now;
      imp_reg <= imp_next;
      // muting forces both rails low; mute pin low lets data pass
      if (mute_now) begin
        receive_positive_data_out_reg <= 1'b0;
        receive_negative_data_out_reg <= 1'b0;
      end else if (rx_edge) begin
        receive_positive_data_out_reg <= s2_reg[1];
        receive_negative_data_out_reg <= s2_reg[2];
      end
      if (tx_edge) begin
        transmit_positive_data_in_reg <= s2_reg[5];
        transmit_negative_data_in_reg <= s2_reg[6];
      end
    end
  end
endmodule // lsp_chan

/* File: hw/lsp_top.v */
`timescale 1ns/1ps
`include "lsp_consts.vh"
module lsp_top #(
  parameter NCH = 8
) (
  input wire clk,
  input wire rst_n,
  input wire host_mode_pin,
  input wire receive_mute_pin,
  input wire [1:0] external_receive_resistor_code,
  input wire [1:0] termination_impedance_select,
  input wire receive_clock_edge_select,
  input wire transmit_clock_edge_select,
  input wire [NCH-1:0] recovered_clock,
  input wire [NCH-1:0] receive_positive_data_raw,
  input wire [NCH-1:0] receive_negative_data_raw,
  input wire [NCH-1:0] receive_loss_of_signal,
  input wire [NCH-1:0] transmit_clock,
  input wire [NCH-1:0] transmit_positive_data_in,
  input wire [NCH-1:0] transmit_negative_data_in,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata_reg,
  output wire [NCH-1:0] receive_positive_data_out,
  output wire [NCH-1:0] receive_negative_data_out,
  output wire [NCH-1:0] transmit_positive_sampled,
  output wire [NCH-1:0] transmit_negative_sampled,
  output wire [16*NCH-1:0] internal_impedance_ohms,
  output reg [1:0] host_processor_type_select_reg,
  output reg host_bus_second_reg,
  output reg host_bus_valid_reg
);
  // strap bits: host, mute, res[1:0], term[1:0], receive_clock_edge_select, transmit_clock_edge_select
  reg [7:0] st1_reg;
  reg [7:0] st2_reg;
  reg [7:0] st3_reg;
  reg [1:0] fill_reg;
  reg [7:0] strap_reg;
  reg strap_done_reg;
  reg [3:0] cfg_reg [0:NCH-1];
  wire [NCH-1:0] los_w;
  wire [NCH-1:0] muted_w;
  wire hw_mode = ~strap_reg[7];
  wire mute_live = st2_reg[6];
  wire cfg_hit = (addr[7:5] == 3'h0) && (addr[1:0] == 2'h0);
  integer i;

  always @(posedge clk) begin
    if (!rst_n) begin
      st1_reg <= 8'h00;
      st2_reg <= 8'h00;
      st3_reg <= 8'h00;
      fill_reg <= 2'h0;
      strap_reg <= 8'h00;
      strap_done_reg <= 1'b0;
      host_processor_type_select_reg <= 2'h0;
      host_bus_second_reg <= 1'b0;
      host_bus_valid_reg <= 1'b0;
    end else begin
      st1_reg <= {host_mode_pin, receive_mute_pin,
                  external_receive_resistor_code,
                  termination_impedance_select,
                  receive_clock_edge_select, transmit_clock_edge_select};
      st2_reg <= st1_reg;
      st3_reg <= st2_reg;
      if (fill_reg != `LSP_SYNC_FILL) begin
        fill_reg <= fill_reg + 2'h1;
      end
      // reset values never latch: wait for real samples that agree
      if (!strap_done_reg && fill_reg == `LSP_SYNC_FILL &&
          st2_reg == st3_reg) begin
        strap_reg <= st2_reg;
        strap_done_reg <= 1'b1;
        host_processor_type_select_reg <= {st2_reg[0], st2_reg[1]};
        if (st2_reg[7]) begin
          host_bus_second_reg <=
            ({st2_reg[0], st2_reg[1]} == `LSP_BUS_SECOND);
          host_bus_valid_reg <=
            ({st2_reg[0], st2_reg[1]} == `LSP_BUS_FIRST) ||
            ({st2_reg[0], st2_reg[1]} == `LSP_BUS_SECOND);
        end
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      for (i = 0; i < NCH; i = i + 1) begin
        cfg_reg[i] <= `LSP_CFG_RESET;
      end
    end else if (wr_stb && cfg_hit && addr[4:2] < NCH) begin
      cfg_reg[addr[4:2]] <= wdata[3:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 32'h00000000;
    end else if (rd_stb) begin
      if (cfg_hit && addr[4:2] < NCH) begin
        rdata_reg <= {28'h0000000, cfg_reg[addr[4:2]]};
      end else if (addr == `LSP_STATUS_ADDR) begin
        rdata_reg <= {16'h0000, muted_w, los_w};
      end else if (addr == `LSP_STRAP_ADDR) begin
        rdata_reg <= {20'h00000, host_bus_valid_reg, host_bus_second_reg,
                      strap_done_reg, 1'b0, strap_reg};
      end else begin
        rdata_reg <= 32'h00000000;
      end
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      wire [1:0] res_sel = hw_mode ? strap_reg[5:4] :
                           cfg_reg[g][`LSP_CFG_RES_LSB+1:`LSP_CFG_RES_LSB];
      wire [1:0] term_sel = hw_mode ? strap_reg[3:2] :
                            cfg_reg[g][`LSP_CFG_TERM_LSB+1:`LSP_CFG_TERM_LSB];
      lsp_chan u_chan (
        .clk(clk),
        .rst_n(rst_n),
        .rclk_pin(recovered_clock[g]),
        .rx_pos_raw(receive_positive_data_raw[g]),
        .rx_neg_raw(receive_negative_data_raw[g]),
        .los_raw(receive_loss_of_signal[g]),
        .tclk_pin(transmit_clock[g]),
        .tx_pos_pin(transmit_positive_data_in[g]),
        .tx_neg_pin(transmit_negative_data_in[g]),
        .mute_en(hw_mode & strap_done_reg & mute_live),
        .rclk_fall(hw_mode & strap_reg[1]),
        .tclk_rise(hw_mode & strap_reg[0]),
        .res_code(res_sel),
        .term_code(term_sel),
        .receive_positive_data_out_reg(receive_positive_data_out[g]),
        .receive_negative_data_out_reg(receive_negative_data_out[g]),
        .transmit_positive_data_in_reg(transmit_positive_sampled[g]),
        .transmit_negative_data_in_reg(transmit_negative_sampled[g]),
        .los_reg(los_w[g]),
        .muted_reg(muted_w[g]),
        .imp_reg(internal_impedance_ohms[16*g+15:16*g])
      );
    end
  endgenerate
endmodule // lsp_top

/* File: sim/lsp_props_properties.sv */
`timescale 1ns/1ps
module lsp_props #(
  parameter NCH = 8
) (
  input wire clk,
  input wire rst_n,
  input wire host_mode_pin,
  input wire receive_mute_pin,
  input wire [NCH-1:0] receive_loss_of_signal,
  input wire [NCH-1:0] recovered_clock,
  input wire [NCH-1:0] transmit_clock,
  input wire rd_stb,
  input wire [31:0] rdata_reg,
  input wire [NCH-1:0] receive_positive_data_out,
  input wire [NCH-1:0] transmit_positive_sampled,
  input wire [16*NCH-1:0] internal_impedance_ohms,
  input wire [1:0] host_processor_type_select_reg,
  input wire host_bus_second_reg,
  input wire host_bus_valid_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // cycles since reset release, saturating; settles the latch checks
  reg [3:0] up_cnt_reg;
  always @(posedge clk) begin
    if (!rst_n) begin
      up_cnt_reg <= 4'h0;
    end else if (up_cnt_reg != 4'hF) begin
      up_cnt_reg <= up_cnt_reg + 4'h1;
    end
  end
  AST_MUTE: assert property (
    (!host_mode_pin && receive_mute_pin && receive_loss_of_signal[0])[*8]
    |-> !receive_positive_data_out[0]) else $error("mute not applied");
  AST_RX_EDGE: assert property (
    $changed(receive_positive_data_out[0]) && !$past(receive_mute_pin, 6)
    |-> $past(recovered_clock[0], 1) != $past(recovered_clock[0], 6))
    else $error("rx change without clock edge");
  AST_TX_EDGE: assert property (
    $changed(transmit_positive_sampled[0])
    |-> $past(transmit_clock[0], 1) != $past(transmit_clock[0], 6))
    else $error("tx change without clock edge");
  AST_RDATA: assert property (
    !$past(rd_stb) |-> rdata_reg == 32'h0) else $error("stray read data");
  AST_SECOND: assert property (
    host_bus_second_reg |-> host_bus_valid_reg &&
    host_processor_type_select_reg == 2'h1) else $error("bad second flag");
  AST_VALID: assert property (
    host_bus_valid_reg |-> host_mode_pin && !host_processor_type_select_reg[1])
    else $error("bad valid flag");
  AST_IMP: assert property (
    !host_mode_pin && up_cnt_reg == 4'hF |-> $stable(internal_impedance_ohms))
    else $error("impedance moved");
  AST_LATCH: assert property (
    up_cnt_reg == 4'hF |-> $stable(host_processor_type_select_reg))
    else $error("type code moved");
endmodule // lsp_props
bind lsp_top lsp_props #(.NCH(NCH)) i_lsp_props (.clk(clk), .rst_n(rst_n),
  .host_mode_pin(host_mode_pin), .receive_mute_pin(receive_mute_pin),
  .receive_loss_of_signal(receive_loss_of_signal), .rd_stb(rd_stb),
  .recovered_clock(recovered_clock), .transmit_clock(transmit_clock),
  .rdata_reg(rdata_reg),
  .receive_positive_data_out(receive_positive_data_out),
  .transmit_positive_sampled(transmit_positive_sampled),
  .internal_impedance_ohms(internal_impedance_ohms),
  .host_processor_type_select_reg(host_processor_type_select_reg),
  .host_bus_second_reg(host_bus_second_reg),
  .host_bus_valid_reg(host_bus_valid_reg));

/* File: sim/lsp_framer.sv */
`timescale 1ns/1ps
module lsp_framer (
  input wire clk,
  input wire rst_n,
  output wire line_clk,
  output wire [7:0] pos,
  output wire [7:0] neg,
  output reg [3:0] phase,
  output reg [7:0] rise_v,
  output reg [7:0] fall_v
);
  reg d;
  assign line_clk = phase[3];
  assign pos = {8{d}} ^ 8'hA5;
  assign neg = ~pos;
  always @(posedge clk) begin
    if (!rst_n) begin
      phase <= 4'h0;
      d <= 1'b0;
    end else begin
      phase <= phase + 4'h1;
      // data moves mid-phase, clear of both clock edges
      if (phase[2:0] == 3'h3) d <= ~d;
      if (phase == 4'h7) rise_v <= pos;
      if (phase == 4'hF) fall_v <= pos;
    end
  end
endmodule // lsp_framer

/* File: sim/tb_liu_strap_pin_config.sv */
`timescale 1ns/1ps
`include "lsp_consts.vh"
module tb_liu_strap_pin_config;
  reg clk = 0, rst_n = 0, hm = 0, mute = 0;
  reg rce = 0, tce = 0, wr = 0, rd = 0;
  reg [1:0] res = 0, term = 0;
  reg [7:0] addr = 0, los = 0;
  reg [31:0] wdata = 0, v;
  wire lc, sec, val;
  wire [1:0] pts;
  wire [3:0] ph;
  wire [7:0] fp, fn, rv, fv, rp, rn, tp, tn;
  wire [31:0] rdata;
  wire [127:0] imp;
  integer failures = 0, num_checks = 0, i, j, k;
  initial forever #5 clk = ~clk;
  lsp_framer i_lsp_framer (.clk(clk), .rst_n(rst_n), .line_clk(lc), .pos(fp),
    .neg(fn), .phase(ph), .rise_v(rv), .fall_v(fv));
  lsp_top i_lsp_top (.clk(clk), .rst_n(rst_n), .host_mode_pin(hm),
    .receive_mute_pin(mute), .external_receive_resistor_code(res),
    .termination_impedance_select(term), .receive_clock_edge_select(rce),
    .transmit_clock_edge_select(tce), .recovered_clock({8{lc}}),
    .receive_positive_data_raw(fp), .receive_negative_data_raw(fn),
    .receive_loss_of_signal(los), .transmit_clock({8{lc}}),
    .transmit_positive_data_in(fp), .transmit_negative_data_in(fn),
    .addr(addr), .wdata(wdata), .wr_stb(wr), .rd_stb(rd), .rdata_reg(rdata),
    .receive_positive_data_out(rp), .receive_negative_data_out(rn),
    .transmit_positive_sampled(tp), .transmit_negative_sampled(tn),
    .internal_impedance_ohms(imp), .host_processor_type_select_reg(pts),
    .host_bus_second_reg(sec), .host_bus_valid_reg(val));
  task results; begin
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  end endtask
  task check(input string nm, input [31:0] seen, input [31:0] exp); begin
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  end endtask
  task restart(input h, input m, input [1:0] r, input [1:0] t, input e, f);
  begin
    @(posedge clk) {rst_n, hm, mute, res, term, rce, tce} <=
      {1'b0, h, m, r, t, e, f};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
  end endtask
  task at7; begin
    for (k = 0; k < 40 && ph !== 4'h7; k = k + 1) @(negedge clk);
    if (k == 40) begin failures = failures + 1; results; end
  end endtask
  task rreg(input [7:0] a); begin
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) v = rdata;
  end endtask
  function [15:0] ex(input [1:0] r, input [1:0] t);
    reg [31:0] a, b, q;
    begin
      a = r == 2'h1 ? `LSP_OHM_240 : r == 2'h2 ? `LSP_OHM_210 : `LSP_OHM_150;
      b = t == 2'h0 ? `LSP_TERM_0 : t == 2'h1 ? `LSP_TERM_1 :
        t == 2'h2 ? `LSP_TERM_2 : `LSP_TERM_3;
      q = a * b / (a - b);
      ex = r == 2'h0 ? b[15:0] : q[15:0];
    end
  endfunction
  task sc_imp; for (i = 0; i < 16; i = i + 1) begin
    restart(1'b0, 1'b0, i[3:2], i[1:0], 1'b0, 1'b0);
    v = {2{ex(i[3:2], i[1:0])}};
    check("imp", {imp[127:112], imp[15:0]}, v);
  end endtask
  task sc_edge; begin
    los <= 8'hFF;
    for (i = 0; i < 4; i = i + 1) begin
      restart(1'b0, 1'b0, 2'h0, 2'h0, i[0], i[1]);
      at7;
      check("rx", {rp, rn}, i[0] ? {fv, ~fv} : {rv, ~rv});
      check("tx", {tp, tn}, i[1] ? {rv, ~rv} : {fv, ~fv});
    end
    @(posedge clk) {rce, tce} <= 2'h0;
    repeat (20) @(negedge clk);
    at7;
    check("latched", {rp, tp}, {fv, rv});
  end endtask
  task sc_mute; begin
    los <= 8'h0F;
    restart(1'b0, 1'b1, 2'h0, 2'h0, 1'b0, 1'b0);
    at7;
    check("mute", {rp, rn}, {rv & 8'hF0, ~rv & 8'hF0});
    rreg(`LSP_STATUS_ADDR);
    check("status", v, 32'h00000F0F);
    @(posedge clk) mute <= 1'b0;
    repeat (20) @(negedge clk);
    at7;
    check("unmute", {rp, rn}, {rv, ~rv});
  end endtask
  task sc_host; begin
    for (i = 0; i < 4; i = i + 1) begin
      restart(1'b1, 1'b1, 2'h3, 2'h3, i[0], i[1]);
      check("bus", {pts, sec, val}, {i[1:0], i == 1, i < 2});
    end
    @(posedge clk) {addr, wdata, wr} <= {`LSP_CFG_BASE + 8'h08, 32'h9, 1'b1};
    @(posedge clk) wr <= 1'b0;
    rreg(`LSP_CFG_BASE + 8'h08);
    check("cfg", v, 32'h00000009);
    v = {ex(2'h1, 2'h2), ex(2'h0, 2'h0)};
    check("imp2", {imp[47:32], imp[15:0]}, v);
    rreg(8'h30);
    check("unmapped", v, 32'h00000000);
    rreg(`LSP_STRAP_ADDR);
    check("strap", v, 32'h000002FF);
  end endtask
  initial begin
    sc_imp;
    sc_edge;
    sc_mute;
    sc_host;
    results;
  end
endmodule // tb_liu_strap_pin_config
